// *** inc/hsf_pkg.sv ***
// Purpose: Shared constants and types of the hot swap fault sequencer.
// Assumes: 200 MHz timebase clock.
// Notes: Times are kept in their own unit; cycle counts derive from them.
package hsf_pkg;
   // Timebase period
   localparam int unsigned CLK_PERIOD_NS = 5;
   // Filter and delay times, as printed
   localparam int unsigned T_FILT_MS_NS = 1000000; // 1.0 ms fault filter
   localparam int unsigned T_OT_NS = 12000; // 12 us over-temperature filter
   localparam int unsigned T_OC_FILT_NS = 100000; // 100 us overcurrent filter
   localparam int unsigned T_OC_REG_MS = 3; // 3.0 ms overcurrent regulation
   localparam int unsigned T_PG_DLY_MS = 20; // 20 ms power-good delay
   localparam int unsigned T_TMR_DEF_MS = 200; // Default delay timer
   localparam int unsigned T_TMR_MIN_MS = 100; // Shortest external setting
   localparam int unsigned T_TMR_MAX_MS = 1000; // Longest external setting
   // Cycle counts; least times round up
   localparam int unsigned MS_CYC_DEF = (T_FILT_MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OT_CYC = (T_OT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OC_FILT_CYC_DEF = (T_OC_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Retry limit and field widths
   localparam int unsigned RETRY_MAX = 10;
   localparam int unsigned RETRY_W = 4;
   localparam int unsigned TMR_W = 10;
   // Sequencer states
   typedef enum logic [1:0] {
      HSF_WAIT = 2'h0, // Delay timer running, switch off
      HSF_CHARGE = 2'h1, // Charging the load capacitor
      HSF_PGDLY = 2'h2, // Fully enhanced, power-good delay
      HSF_NORMAL = 2'h3 // Normal operation
   } hsf_state_t;
endpackage : hsf_pkg

// *** verilog/hsf_sync.sv ***
// Purpose: Two-flop synchroniser for one asynchronous indication.
// Assumes: Single clock domain downstream.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module hsf_sync (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic async_i,
   output logic sync_o
);
   logic meta_q; // First stage, read only by sync_o
   logic meta_d;
   logic sync_d;
   // Next values
   always_comb begin
      meta_d = async_i;
      sync_d = meta_q;
   end
   // Two stages in series
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_q <= 1'b0;
         sync_o <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_o <= sync_d;
      end
   end
endmodule // hsf_sync
`default_nettype wire

// *** verilog/hsf_filt.sv ***
// Purpose: Persistence filter for one synchronised indication.
// Assumes: Input already synchronous to mclk_i.
// Notes: SYMM=1 qualifies both edges; otherwise only the rising one.
`timescale 1ns/1ps
`default_nettype none
module hsf_filt #(
   parameter int unsigned TC = 16, // Terminal count in cycles
   parameter bit SYMM = 1'b0 // Filter the release too
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic in_i,
   output logic flag_o
);
   localparam int unsigned CW = $clog2(TC + 1);
   logic [CW-1:0] cnt_q; // Persistence counter
   logic [CW-1:0] cnt_d;
   logic flag_d;
   // Count while the input differs from the qualified level
   always_comb begin
      cnt_d = '0;
      flag_d = flag_o;
      if (in_i != flag_o) begin
         if (!in_i && !SYMM) begin
            flag_d = 1'b0; // Release is immediate
         end else if (cnt_q == CW'(TC - 1)) begin
            flag_d = in_i;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end
   // Registers
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q <= '0;
         flag_o <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         flag_o <= flag_d;
      end
   end
   a_filt_term: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      $changed(flag_o) && flag_o |-> $past(cnt_q) == CW'(TC - 1))
      else $error("filter flagged before terminal count");
   a_filt_restart: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (in_i == flag_o) |=> cnt_q == '0)
      else $error("filter counter did not restart");
endmodule // hsf_filt
`default_nettype wire

// *** verilog/hsf_seq.sv ***
// Purpose: Start-up, retry and fault sequencing of a hot swap controller.
// Assumes: Comparator indications are asynchronous, active high.
// Notes: One ms prescaler paces the delay timer, power-good delay and
//        overcurrent regulation window.
// Functional notes
// - Power-good pair asserted only in normal operation
// - Disable over 1.0 ms drops power-good
// - Over-temperature over 12 us drops power-good
// - Over/undervoltage over 1.0 ms drops power-good
// - Overcurrent over 3.0 ms drops power-good
// - One delay timer paces start-up and retry
// - Timer 200 ms default, else 100-1000 ms
// - Qualified overvoltage: switch off until clear
// - Overvoltage filtered for 1.0 ms
// - Qualified undervoltage: switch off until clear
// - Undervoltage filtered for 1.0 ms
// - Inactive disable means enabled
// - Disable changes filtered for 1.0 ms
// - Disable clears latched fault state
// - Overcurrent filtered for 100 us
// - Charge limit in start-up, overcurrent limit otherwise
// - Start after full timer period, retries at most 10
// - Enhanced: 20 ms, power-good, retries cleared
// - Violation switches off, restarts timer cycle
`timescale 1ns/1ps
`default_nettype none
module hsf_seq #(
   parameter int unsigned MS_CYC = hsf_pkg::MS_CYC_DEF, // Cycles per ms
   parameter int unsigned OC_FILT_CYC = hsf_pkg::OC_FILT_CYC_DEF // Overcurrent filter
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic overvoltage_sense_i, // Above overvoltage threshold
   input wire logic undervoltage_sense_i, // Below undervoltage threshold
   input wire logic overtemp_sense_i, // Die above shutdown temperature
   input wire logic overcurrent_sense_i, // Load above overcurrent limit
   input wire logic disable_req_i, // Disable pin away from inactive level
   input wire logic full_enh_i, // Switch reached full enhancement
   input wire logic timer_ext_i, // External timer setting present
   input wire logic [hsf_pkg::TMR_W-1:0] timer_ms_i, // External setting in ms
   output logic switch_en_o, // Pass element enable
   output logic charge_limit_sel_o, // 1: charge limit, 0: overcurrent limit
   output logic power_good_out_o, // Active high power good
   output logic power_good_out_b_o, // Active low power good
   output logic oc_mode_o, // Overcurrent regulation active
   output logic [hsf_pkg::RETRY_W-1:0] retry_cnt_o // Retry counter
);
   localparam int unsigned PW = $clog2(MS_CYC + 1);
   localparam int unsigned TW = hsf_pkg::TMR_W;
   localparam int unsigned RW = hsf_pkg::RETRY_W;

   // Synchronised indications, one per fault or disable input
   logic [4:0] raw_w;
   logic [4:0] syn_w;
   // Qualified indications
   logic ov_q;
   logic uv_q;
   logic ot_q;
   logic dis_q;
   logic oc_q;

   assign raw_w = {disable_req_i, overcurrent_sense_i, overtemp_sense_i,
                   undervoltage_sense_i, overvoltage_sense_i};

   // One synchroniser per indication
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_sync
         hsf_sync u_sync (
            .mclk_i(mclk_i),
            .rst_b_i(rst_b_i),
            .async_i(raw_w[gi]),
            .sync_o(syn_w[gi])
         );
      end
   endgenerate

   // Fault filters
   hsf_filt #(.TC(MS_CYC), .SYMM(1'b0)) u_ov_filt (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .in_i(syn_w[0]),
      .flag_o(ov_q)
   );
   hsf_filt #(.TC(MS_CYC), .SYMM(1'b0)) u_uv_filt (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .in_i(syn_w[1]),
      .flag_o(uv_q)
   );
   hsf_filt #(.TC(hsf_pkg::OT_CYC), .SYMM(1'b0)) u_ot_filt (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .in_i(syn_w[2]),
      .flag_o(ot_q)
   );
   hsf_filt #(.TC(OC_FILT_CYC), .SYMM(1'b0)) u_oc_filt (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .in_i(syn_w[3]),
      .flag_o(oc_q)
   );
   // Disable is qualified in both directions so a glitch cannot re-enable
   hsf_filt #(.TC(MS_CYC), .SYMM(1'b1)) u_dis_filt (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .in_i(syn_w[4]),
      .flag_o(dis_q)
   );

   // Sequencer state
   hsf_pkg::hsf_state_t state_q;
   hsf_pkg::hsf_state_t state_d;
   logic [PW-1:0] pre_q; // Cycle prescaler to one ms
   logic [PW-1:0] pre_d;
   logic [TW-1:0] ms_q; // Millisecond count of the current phase
   logic [TW-1:0] ms_d;
   logic [RW-1:0] retry_d;
   logic ot_p_q; // Previous qualified over-temperature
   logic dis_p_q; // Previous qualified disable
   logic sw_d;
   logic chg_d;
   logic pg_d;
   logic ocm_d;
   // Combinational helpers
   logic ok_w; // All start-up conditions hold
   logic tick_w; // Last cycle of a millisecond
   logic [TW-1:0] tmr_len_w; // Delay timer length in ms
   logic restart_w; // Phase timing restarts
   logic oc_trip_w; // Overcurrent outlasted regulation window

   // Timer length: default without a setting, else clamped setting
   always_comb begin
      if (!timer_ext_i) begin
         tmr_len_w = TW'(hsf_pkg::T_TMR_DEF_MS);
      end else if (timer_ms_i < TW'(hsf_pkg::T_TMR_MIN_MS)) begin
         tmr_len_w = TW'(hsf_pkg::T_TMR_MIN_MS);
      end else if (timer_ms_i > TW'(hsf_pkg::T_TMR_MAX_MS)) begin
         tmr_len_w = TW'(hsf_pkg::T_TMR_MAX_MS);
      end else begin
         tmr_len_w = timer_ms_i;
      end
   end

   // Condition checks
   always_comb begin
      ok_w = !ov_q && !uv_q && !ot_q && !dis_q;
      tick_w = (pre_q == PW'(MS_CYC - 1));
      oc_trip_w = (state_q == hsf_pkg::HSF_NORMAL) && oc_q && tick_w &&
                  (ms_q == TW'(hsf_pkg::T_OC_REG_MS - 1));
   end

   // Next state and outputs
   always_comb begin
      state_d = state_q;
      retry_d = retry_cnt_o;
      case (state_q)
         hsf_pkg::HSF_WAIT: begin
            // Full timer period of good conditions and retries in range
            if (ok_w && tick_w && (ms_q == tmr_len_w - 1'b1) &&
                (retry_cnt_o <= RW'(hsf_pkg::RETRY_MAX))) begin
               state_d = hsf_pkg::HSF_CHARGE;
            end
         end
         hsf_pkg::HSF_CHARGE: begin
            if (!ok_w) begin
               state_d = hsf_pkg::HSF_WAIT;
            end else if (full_enh_i) begin
               state_d = hsf_pkg::HSF_PGDLY;
            end
         end
         hsf_pkg::HSF_PGDLY: begin
            if (!ok_w) begin
               state_d = hsf_pkg::HSF_WAIT;
            end else if (tick_w && (ms_q == TW'(hsf_pkg::T_PG_DLY_MS - 1))) begin
               state_d = hsf_pkg::HSF_NORMAL;
               retry_d = '0;
            end
         end
         hsf_pkg::HSF_NORMAL: begin
            if (!ok_w || oc_trip_w) begin
               state_d = hsf_pkg::HSF_WAIT;
            end
         end
         default: begin
            state_d = hsf_pkg::HSF_WAIT;
         end
      endcase
      // Temperature, disable and overcurrent restarts are counted
      if (((ot_q && !ot_p_q) || (dis_q && !dis_p_q) || oc_trip_w) &&
          (retry_cnt_o != '1)) begin
         retry_d = retry_cnt_o + 1'b1;
      end
      // Re-enabling clears the latched retry count
      if (!dis_q && dis_p_q) begin
         retry_d = '0;
      end
      // Phase timing restarts on any state change, bad conditions while
      // waiting, or leaving overcurrent regulation
      restart_w = (state_d != state_q) || !ok_w ||
                  ((state_q == hsf_pkg::HSF_NORMAL) && !oc_q);
      pre_d = (restart_w || tick_w) ? '0 : pre_q + 1'b1;
      if (restart_w) begin
         ms_d = '0;
      end else begin
         ms_d = tick_w ? ms_q + 1'b1 : ms_q;
      end
      // Outputs follow the next state so they leave flops directly
      sw_d = (state_d != hsf_pkg::HSF_WAIT);
      chg_d = (state_d == hsf_pkg::HSF_CHARGE);
      pg_d = (state_d == hsf_pkg::HSF_NORMAL);
      ocm_d = pg_d && oc_q;
   end

   // State registers
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= hsf_pkg::HSF_WAIT;
         pre_q <= '0;
         ms_q <= '0;
         retry_cnt_o <= '0;
         ot_p_q <= 1'b0;
         dis_p_q <= 1'b0;
         switch_en_o <= 1'b0;
         charge_limit_sel_o <= 1'b0;
         power_good_out_o <= 1'b0;
         power_good_out_b_o <= 1'b1;
         oc_mode_o <= 1'b0;
      end else begin
         state_q <= state_d;
         pre_q <= pre_d;
         ms_q <= ms_d;
         retry_cnt_o <= retry_d;
         ot_p_q <= ot_q;
         dis_p_q <= dis_q;
         switch_en_o <= sw_d;
         charge_limit_sel_o <= chg_d;
         power_good_out_o <= pg_d;
         power_good_out_b_o <= !pg_d;
         oc_mode_o <= ocm_d;
      end
   end

   // Steps of an overcurrent trip
   sequence s_oc_trip;
      (state_q == hsf_pkg::HSF_NORMAL) && oc_trip_w;
   endsequence
   sequence s_all_off;
      !switch_en_o && !power_good_out_o && power_good_out_b_o;
   endsequence
   // Normal operation with no fault and no trip in this cycle
   sequence s_pg_kept;
      power_good_out_o && ok_w && !oc_trip_w;
   endsequence

   a_pg_pair: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      power_good_out_o != power_good_out_b_o)
      else $error("power-good outputs not complementary");
   a_pg_normal: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      power_good_out_o |-> state_q == hsf_pkg::HSF_NORMAL && switch_en_o)
      else $error("power-good outside normal operation");
   a_dis_drop: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      dis_q |=> s_all_off)
      else $error("disable did not drop power-good");
   a_ot_drop: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      ot_q |=> s_all_off)
      else $error("over-temperature did not drop power-good");
   a_volt_off: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (ov_q || uv_q) |=> s_all_off)
      else $error("voltage fault did not switch off");
   a_oc_trip: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      s_oc_trip |=> s_all_off ##1 (state_q == hsf_pkg::HSF_WAIT))
      else $error("overcurrent trip did not switch off");
   a_start_gate: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      $rose(switch_en_o) |-> $past(retry_cnt_o) <= RW'(hsf_pkg::RETRY_MAX)
      && $past(ms_q) == $past(tmr_len_w) - 1'b1)
      else $error("switch started before timer or over retry limit");
   a_limit_sel: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (state_q == hsf_pkg::HSF_CHARGE) == charge_limit_sel_o)
      else $error("wrong current limit selected");
   a_pg_retry: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      $rose(power_good_out_o) |-> retry_cnt_o == '0
      && $past(ms_q) == TW'(hsf_pkg::T_PG_DLY_MS - 1))
      else $error("power-good without delay or retry clear");
   a_viol_wait: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (switch_en_o && !ok_w) |=> state_q == hsf_pkg::HSF_WAIT && ms_q == '0)
      else $error("violation did not restart the timer");
   // A held fault or the retry limit keeps a stopped switch stopped
   a_ov_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (ov_q && !switch_en_o) |=> !switch_en_o)
      else $error("switch started during overvoltage");
   a_uv_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (uv_q && !switch_en_o) |=> !switch_en_o)
      else $error("switch started during undervoltage");
   a_retry_lock: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (retry_cnt_o > RW'(hsf_pkg::RETRY_MAX)) && !switch_en_o |=> !switch_en_o)
      else $error("switch started beyond the retry limit");
   // A short overcurrent keeps power-good and only shows regulation
   a_pg_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      s_pg_kept |=> power_good_out_o)
      else $error("power-good dropped without a fault");
   a_oc_mode: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      s_pg_kept ##0 oc_q |=> oc_mode_o)
      else $error("qualified overcurrent not shown as regulation");
endmodule // hsf_seq
`default_nettype wire

// *** verification/hsf_load_model.sv ***
// Purpose: Downstream load model: capacitor charge and power-module enable.
// Assumes: One clock; chg_cyc_i sets how long the capacitor takes to charge.
// Notes: A pair fault is sticky so that a short glitch is never missed.
`timescale 1ns/1ps
`default_nettype none
module hsf_load_model (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic switch_en_i, // Pass element on
   input wire logic power_good_i, // Active high enable of the module
   input wire logic power_good_b_i, // Active low enable of the module
   input wire logic [7:0] chg_cyc_i, // Cycles to full enhancement
   output logic full_enh_o, // Capacitor charged, switch fully on
   output logic load_on_o, // Power module running
   output logic pair_err_o // Power-good pair ever disagreed
);
   logic [7:0] chg_q; // Charge progress

   // Capacitor charges only while the switch conducts; it is lost at turn-off
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         chg_q <= 8'h00;
         pair_err_o <= 1'b0;
      end else begin
         if (!switch_en_i) begin
            chg_q <= 8'h00;
         end else if (chg_q != chg_cyc_i) begin
            chg_q <= chg_q + 8'h01;
         end
         // Module is enabled only by a consistent pair
         if (power_good_i === power_good_b_i) begin
            pair_err_o <= 1'b1;
         end
      end
   end

   // Full enhancement reached once the charge count is complete
   assign full_enh_o = switch_en_i && (chg_q == chg_cyc_i);
   assign load_on_o = power_good_i && !power_good_b_i;
endmodule // hsf_load_model
`default_nettype wire

// *** verification/tb.sv ***
// Purpose: Self-checking bench of the hot swap fault sequencer.
// Assumes: MS_CYC=20 and OC_FILT_CYC=4 shorten every ms-based count.
// Notes: Times are checked in windows that allow for sync and filter slack.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) check_val(nm, 16'(e), 16'(g))
module tb;
   localparam int MS = 20; // Cycles per ms in this run
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic ov = 1'b0, uv = 1'b0, ot = 1'b0, oc = 1'b0, dis = 1'b0;
   logic full_enh, timer_ext = 1'b0;
   logic [9:0] timer_ms = 10'h064;
   logic [7:0] chg_cyc = 8'h0A;
   logic sw, chg_sel, pg, pg_b, oc_mode, load_on, pair_err;
   logic [3:0] retry;
   int miscompares = 0;
   int n_checks = 0;
   int cyc = 0;
   int n;

   // 200 MHz timebase
   always #2.5 mclk_i = ~mclk_i;

   hsf_seq #(.MS_CYC(20), .OC_FILT_CYC(4)) dut (
      .mclk_i(mclk_i), .rst_b_i(rst_b_i), .overvoltage_sense_i(ov),
      .undervoltage_sense_i(uv), .overtemp_sense_i(ot), .overcurrent_sense_i(oc),
      .disable_req_i(dis), .full_enh_i(full_enh), .timer_ext_i(timer_ext),
      .timer_ms_i(timer_ms), .switch_en_o(sw), .charge_limit_sel_o(chg_sel),
      .power_good_out_o(pg), .power_good_out_b_o(pg_b), .oc_mode_o(oc_mode),
      .retry_cnt_o(retry));

   hsf_load_model load (
      .mclk_i(mclk_i), .rst_b_i(rst_b_i), .switch_en_i(sw), .power_good_i(pg),
      .power_good_b_i(pg_b), .chg_cyc_i(chg_cyc), .full_enh_o(full_enh),
      .load_on_o(load_on), .pair_err_o(pair_err));

   // Verdict and end of run, reached from the main flow or the hang guard
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check_val(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   function automatic logic in_win(input int v, input int lo, input int hi);
      return (v >= lo) && (v <= hi);
   endfunction

   // Drive one indication just after a rising edge
   task automatic drive(input int k, input logic v);
      @(posedge mclk_i);
      case (k)
         0: ov <= v;
         1: uv <= v;
         2: ot <= v;
         3: dis <= v;
         default: oc <= v;
      endcase
   endtask

   // Count settled cycles until an output reaches a level; maxc on timeout
   task automatic wait_for(input int k, input logic v, input int maxc, output int cnt);
      logic s;
      for (cnt = 0; cnt < maxc; cnt++) begin
         @(negedge mclk_i);
         s = (k == 0) ? sw : (k == 1) ? pg : oc_mode;
         if (s === v) begin
            break;
         end
      end
   endtask

   // Start-up after a clean timer period, charge, then power-good delay
   task automatic bring_up(input int t);
      int pg_at; // Charge time of the load plus the 20 ms delay
      wait_for(0, 1'b1, t + 100, n);
      `CHK("start time", 1'b1, in_win(n, t - 10, t + 60));
      `CHK("charge limit", 1'b1, chg_sel);
      `CHK("pg early", 1'b0, pg);
      pg_at = 20 * MS + int'(chg_cyc);
      wait_for(1, 1'b1, 600, n);
      `CHK("pg delay", 1'b1, in_win(n, pg_at - 2, pg_at + 6));
      `CHK("oc limit", 1'b0, chg_sel);
      `CHK("pg low out", 1'b0, pg_b);
      `CHK("retry clear", 4'h0, retry);
   endtask

   // Hang guard: the planned run is about 51500 cycles
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 100000) begin
         miscompares++;
         wrap_up();
      end
   end

   initial begin
      repeat (2) @(posedge mclk_i);
      @(negedge mclk_i);
      `CHK("rst sw", 1'b0, sw);
      `CHK("rst pg", 2'b01, {pg, pg_b});
      `CHK("rst retry", 4'h0, retry);
      @(posedge mclk_i);
      rst_b_i <= 1'b1;
      // Default timer with no external setting, inactive disable = enabled
      bring_up(200 * MS);
      timer_ext <= 1'b1; // External 50 ms clamps to the 100 ms floor
      timer_ms <= 10'h032;
      // Overcurrent shorter than its filter is ignored
      drive(4, 1'b1);
      drive(4, 1'b0);
      wait_for(2, 1'b1, 12, n);
      `CHK("oc glitch", 12, n);
      // Overcurrent shorter than the regulation window keeps power-good
      drive(4, 1'b1);
      wait_for(2, 1'b1, 20, n);
      `CHK("oc filter", 1'b1, in_win(n, 4, 9));
      repeat (20) @(posedge mclk_i);
      drive(4, 1'b0);
      wait_for(2, 1'b0, 8, n);
      `CHK("oc recover", 1'b1, in_win(n, 0, 7));
      `CHK("oc pg kept", 1'b1, pg);
      // Sustained overcurrent trips after 3 ms of regulation
      drive(4, 1'b1);
      wait_for(2, 1'b1, 20, n);
      wait_for(1, 1'b0, 80, n);
      `CHK("oc trip", 1'b1, in_win(n, 3 * MS - 3, 3 * MS + 3));
      `CHK("oc sw off", 1'b0, sw);
      `CHK("oc retry", 4'h1, retry);
      drive(4, 1'b0);
      bring_up(100 * MS);
      // Over- and undervoltage: glitch ignored, held fault holds switch off
      for (int k = 0; k < 2; k++) begin
         drive(k, 1'b1);
         repeat (14) @(posedge mclk_i);
         drive(k, 1'b0);
         repeat (10) @(negedge mclk_i);
         `CHK("v glitch", 1'b1, pg);
         drive(k, 1'b1);
         wait_for(1, 1'b0, 40, n);
         `CHK("v filter", 1'b1, in_win(n, MS, MS + 7));
         `CHK("v sw off", 1'b0, sw);
         wait_for(0, 1'b1, 2500, n);
         `CHK("v held off", 2500, n);
         `CHK("v no count", 4'h0, retry);
         drive(k, 1'b0);
         bring_up(100 * MS);
      end
      // Over-temperature: 12 us filter, then repeated until retries exceed 10
      drive(2, 1'b1);
      wait_for(1, 1'b0, 2450, n);
      `CHK("ot filter", 1'b1, in_win(n, 2400, 2410));
      for (int i = 0; i < 10; i++) begin
         drive(2, 1'b0);
         repeat (5) @(posedge mclk_i);
         drive(2, 1'b1);
         repeat (2410) @(posedge mclk_i);
      end
      @(negedge mclk_i);
      `CHK("ot retries", 4'hB, retry);
      drive(2, 1'b0);
      wait_for(0, 1'b1, 2500, n);
      `CHK("retry lockout", 2500, n);
      // Disable pulse clears the latched retry count
      drive(3, 1'b1);
      repeat (30) @(posedge mclk_i);
      drive(3, 1'b0);
      repeat (30) @(negedge mclk_i);
      `CHK("dis clears", 4'h0, retry);
      chg_cyc <= 8'h60; // Slow capacitor this time
      bring_up(100 * MS);
      // Disable glitch ignored, held disable drops power-good
      drive(3, 1'b1);
      repeat (14) @(posedge mclk_i);
      drive(3, 1'b0);
      repeat (30) @(negedge mclk_i);
      `CHK("dis glitch", 1'b1, pg);
      drive(3, 1'b1);
      wait_for(1, 1'b0, 40, n);
      `CHK("dis filter", 1'b1, in_win(n, MS, MS + 7));
      `CHK("dis sw off", 1'b0, sw);
      `CHK("dis retry", 4'h1, retry);
      drive(3, 1'b0);
      timer_ms <= 10'h078; // 120 ms lies inside the range and is taken as set
      bring_up(120 * MS);
      `CHK("load on", 1'b1, load_on);
      `CHK("pg pair", 1'b0, pair_err);
      wrap_up();
   end
endmodule // tb
`default_nettype wire
